/* File: hdl/asrc_host.sv */
// host controller driving an asynchronous 256k x 16 static memory
`timescale 1ns/1ps
`include "asrc_consts.svh"
module asrc_host #(
  parameter int ADDR_W = `ASRC_ADDR_W,
  parameter int DATA_W = `ASRC_DATA_W
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // user request
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  input wire logic [1:0] REQ_BYTE_EN,
  output logic REQ_READY,
  // user answer
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_RDATA,
  // memory pins
  output logic [ADDR_W-1:0] WORD_ADDRESS,
  output logic CHIP_SELECT_N,
  output logic WRITE_STROBE_N,
  output logic OUTPUT_DRIVE_N,
  output logic LOW_BYTE_LANE_N,
  output logic HIGH_BYTE_LANE_N,
  output logic [DATA_W-1:0] DATA_LINES_O,
  output logic DATA_LINES_OE,
  input wire logic [DATA_W-1:0] DATA_LINES_I
);
  localparam logic [2:0] RD_CYC = 3'(`ASRC_CYC(`ASRC_T_ACC_PS));
  localparam logic [2:0] WR_CYC = 3'(`ASRC_CYC(`ASRC_T_PWE_PS));
  localparam logic [2:0] HZ_CYC = 3'(`ASRC_CYC(`ASRC_T_HZ_PS));
  if (ADDR_W != `ASRC_ADDR_W || DATA_W != `ASRC_DATA_W) begin : g_bad_geom
    $error("asrc_host: memory is 18-bit address by 16-bit word");
  end
  // the 3-bit phase timer must hold every count, synchroniser slack included
  if (`ASRC_CYC(`ASRC_T_ACC_PS) + 2 > 7 || `ASRC_CYC(`ASRC_T_PWE_PS) > 7
      || `ASRC_CYC(`ASRC_T_HZ_PS) > 7) begin : g_bad_cyc
    $error("asrc_host: phase count does not fit the timer");
  end

  asrc_pkg::asrc_state_t st_r, st_nxt;
  logic [DATA_W-1:0] din_s1_r, din_s2_r;
  logic [2:0] tload_val;
  logic tload, tdone;

  // pin data is asynchronous to CLK, two flops before use
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else if (CE) begin
      din_s1_r <= DATA_LINES_I;
      din_s2_r <= din_s1_r;
    end
  end

  asrc_timer #(.W(3)) u_timer (
    .clk(CLK),
    .nrst(NRST),
    .ce(CE),
    .load(tload),
    .value(tload_val),
    .done(tdone)
  );

  // no enabled lane: skip the write entirely, word stays unchanged
  wire lanes_none = (REQ_BYTE_EN == 2'b00);
  wire take = REQ_VALID && REQ_READY;
  wire take_wr = take && REQ_WRITE && !lanes_none;
  wire take_rd = take && !REQ_WRITE;
  wire take_nop = take && REQ_WRITE && lanes_none;
  // two extra cycles cover the synchroniser on the way back
  wire [2:0] rd_wait = RD_CYC + 3'd2;

  always_comb begin
    st_nxt = st_r;
    tload = 1'b0;
    tload_val = '0;
    case (st_r)
      asrc_pkg::ST_IDLE: begin
        if (take_rd) begin
          st_nxt = asrc_pkg::ST_RD;
          tload = 1'b1;
          tload_val = rd_wait;
        end else if (take_wr) begin
          st_nxt = asrc_pkg::ST_WR;
          tload = 1'b1;
          tload_val = WR_CYC;
        end
      end
      asrc_pkg::ST_RD: begin
        if (tdone) begin
          st_nxt = asrc_pkg::ST_RDDONE;
        end
      end
      asrc_pkg::ST_RDDONE: begin
        st_nxt = asrc_pkg::ST_GAP;
        tload = 1'b1;
        tload_val = HZ_CYC;
      end
      asrc_pkg::ST_WR: begin
        if (tdone) begin
          st_nxt = asrc_pkg::ST_WRHOLD;
        end
      end
      asrc_pkg::ST_WRHOLD: begin
        st_nxt = asrc_pkg::ST_GAP;
        tload = 1'b1;
        tload_val = HZ_CYC;
      end
      asrc_pkg::ST_GAP: begin
        if (tdone) begin
          st_nxt = asrc_pkg::ST_IDLE;
        end
      end
      default: st_nxt = asrc_pkg::ST_IDLE;
    endcase
  end

  // pin levels per state
  wire sel_nxt = (st_nxt == asrc_pkg::ST_RD) || (st_nxt == asrc_pkg::ST_RDDONE)
    || (st_nxt == asrc_pkg::ST_WR);
  wire wr_nxt = (st_nxt == asrc_pkg::ST_WR);
  wire rd_nxt = (st_nxt == asrc_pkg::ST_RD) || (st_nxt == asrc_pkg::ST_RDDONE);
  // data driven through the strobe and one hold cycle after it rises
  wire drv_nxt = wr_nxt || (st_nxt == asrc_pkg::ST_WRHOLD);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= asrc_pkg::ST_IDLE;
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
      WORD_ADDRESS <= '0;
      CHIP_SELECT_N <= 1'b1;
      WRITE_STROBE_N <= 1'b1;
      OUTPUT_DRIVE_N <= 1'b1;
      LOW_BYTE_LANE_N <= 1'b1;
      HIGH_BYTE_LANE_N <= 1'b1;
      DATA_LINES_O <= '0;
      DATA_LINES_OE <= 1'b0;
    end else if (CE) begin
      st_r <= st_nxt;
      REQ_READY <= (st_nxt == asrc_pkg::ST_IDLE) && !take;
      RSP_VALID <= (st_r == asrc_pkg::ST_RD) && tdone;
      if ((st_r == asrc_pkg::ST_RD) && tdone) begin
        RSP_RDATA <= din_s2_r;
      end
      if (take) begin
        WORD_ADDRESS <= REQ_ADDR;
        LOW_BYTE_LANE_N <= !REQ_BYTE_EN[0];
        HIGH_BYTE_LANE_N <= !REQ_BYTE_EN[1];
        DATA_LINES_O <= REQ_WDATA;
      end
      // select only during an access, standby otherwise
      CHIP_SELECT_N <= !sel_nxt;
      // strobe and select fall and rise together: overlap is the write
      WRITE_STROBE_N <= !wr_nxt;
      OUTPUT_DRIVE_N <= !rd_nxt;
      DATA_LINES_OE <= drv_nxt;
    end
  end

  // checks
  property p_wr_overlap;
    @(posedge CLK) disable iff (!NRST) !WRITE_STROBE_N |-> !CHIP_SELECT_N;
  endproperty
  a_wr_overlap: assert property (p_wr_overlap) else $error("strobe without select");
  property p_no_contention;
    @(posedge CLK) disable iff (!NRST) DATA_LINES_OE |-> OUTPUT_DRIVE_N;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention");
  property p_rd_mode;
    @(posedge CLK) disable iff (!NRST) !OUTPUT_DRIVE_N |-> WRITE_STROBE_N && !CHIP_SELECT_N;
  endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("bad read levels");
  property p_wr_len;
    @(posedge CLK) disable iff (!NRST || !CE) $fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*2];
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe too short");
  property p_data_hold;
    @(posedge CLK) disable iff (!NRST || !CE) $rose(WRITE_STROBE_N) |-> DATA_LINES_OE;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("no data hold");
  property p_wr_end;
    @(posedge CLK) disable iff (!NRST || !CE) $rose(WRITE_STROBE_N) |-> CHIP_SELECT_N;
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("select not raised");
  property p_idle_standby;
    @(posedge CLK) disable iff (!NRST || !CE) st_r == asrc_pkg::ST_IDLE |-> CHIP_SELECT_N;
  endproperty
  a_idle_standby: assert property (p_idle_standby) else $error("selected while idle");
  property p_lanes_on_wr;
    @(posedge CLK) disable iff (!NRST)
      !WRITE_STROBE_N |-> !(LOW_BYTE_LANE_N && HIGH_BYTE_LANE_N);
  endproperty
  a_lanes_on_wr: assert property (p_lanes_on_wr) else $error("write with no lane");
  property p_rsp_time;
    @(posedge CLK) disable iff (!NRST || !CE) $fell(OUTPUT_DRIVE_N) |-> ##[1:8] RSP_VALID;
  endproperty
  a_rsp_time: assert property (p_rsp_time) else $error("read answer late");
  // a low enable must hold select, strobe, output drive and the answer valid where they stand
  property p_freeze;
    @(posedge CLK) disable iff (!NRST)
      !CE |=> $stable(CHIP_SELECT_N) && $stable(WRITE_STROBE_N) && $stable(OUTPUT_DRIVE_N)
      && $stable(RSP_VALID);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
  property p_addr_hold;
    @(posedge CLK) disable iff (!NRST)
      !CHIP_SELECT_N && !$past(CHIP_SELECT_N) |-> $stable(WORD_ADDRESS)
      && $stable(LOW_BYTE_LANE_N) && $stable(HIGH_BYTE_LANE_N);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved while selected");
  property p_wr_data;
    @(posedge CLK) disable iff (!NRST)
      !WRITE_STROBE_N && !$past(WRITE_STROBE_N) |-> $stable(DATA_LINES_O) && DATA_LINES_OE;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data moved under strobe");
  c_read: cover property (@(posedge CLK) RSP_VALID);
  c_write: cover property (@(posedge CLK) $rose(WRITE_STROBE_N));
  c_low_only: cover property (@(posedge CLK) !WRITE_STROBE_N && HIGH_BYTE_LANE_N);
  c_nop: cover property (@(posedge CLK) take_nop);
  c_frozen: cover property (@(posedge CLK) !CE && !CHIP_SELECT_N);
endmodule

/* File: common/asrc_consts.svh */
// timing and layout constants for the async static memory host controller
// Overview of operation
// - write only while select and strobe low
// - read: select and drive low, strobe high
// - write ends when select or strobe rises
// - host holds data around terminating strobe edge
`ifndef ASRC_CONSTS_SVH
`define ASRC_CONSTS_SVH
`define ASRC_ADDR_W 18
`define ASRC_DATA_W 16
`define ASRC_CLK_PS 8000
// slowest grade figures, picoseconds
`define ASRC_T_ACC_PS 25000
`define ASRC_T_PWE_PS 15000
`define ASRC_T_SD_PS 10000
`define ASRC_T_HZ_PS 10000
`define ASRC_T_WC_PS 25000
// least times rounded up to whole cycles
`define ASRC_CYC(ps) (((ps) + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS)
`endif

/* File: common/asrc_pkg.sv */
// types for the async static memory host controller
package asrc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD = 3'b001,
    ST_RDDONE = 3'b011,
    ST_WR = 3'b010,
    ST_WRHOLD = 3'b110,
    ST_GAP = 3'b100
  } asrc_state_t;
endpackage

/* File: hdl/asrc_timer.sv */
// down counter that times each phase of a memory cycle
`timescale 1ns/1ps
module asrc_timer #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // control
  input wire logic load,
  input wire logic [W-1:0] value,
  // status
  output logic done
);
  if (W < 1) begin : g_bad_w
    $error("asrc_timer: width must be at least one bit");
  end
  logic [W-1:0] cnt_r;
  assign done = (cnt_r == '0);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_r <= value;
      end else if (!done) begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end
endmodule

/* File: dv/asrc_mem_model.sv */
// behavioural model of the asynchronous 256k x 16 static memory
`timescale 1ns/1ps
module asrc_mem_model (
  // strobes and address
  input wire logic [17:0] word_address,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic low_byte_lane_n,
  input wire logic high_byte_lane_n,
  // host data side
  input wire logic [15:0] host_o,
  input wire logic host_oe,
  // resolved lines and status
  output logic [15:0] data_lines,
  output logic clash,
  output logic standby
);
  logic [15:0] mem [0:262143];
  logic [15:0] last = 16'h0000;
  wire wr_on = !chip_select_n && !write_strobe_n;
  wire rd_on = !chip_select_n && !output_drive_n && write_strobe_n;
  wire lo_drv = rd_on && !low_byte_lane_n;
  wire hi_drv = rd_on && !high_byte_lane_n;
  // released lines show the inverse of the last value the host drove, not a stale copy
  wire [15:0] dev = {hi_drv ? mem[word_address][15:8] : ~last[15:8],
                     lo_drv ? mem[word_address][7:0] : ~last[7:0]};
  assign data_lines = host_oe ? host_o : dev;
  assign clash = host_oe && (lo_drv || hi_drv);
  assign standby = chip_select_n;
  always @(host_o or host_oe) begin
    if (host_oe) last = host_o;
  end
  // data taken at whichever strobe ends the write
  always @(negedge wr_on) begin
    if (host_oe === 1'b1 && low_byte_lane_n === 1'b0) mem[word_address][7:0] = host_o[7:0];
    if (host_oe === 1'b1 && high_byte_lane_n === 1'b0) mem[word_address][15:8] = host_o[15:8];
  end
endmodule

/* File: dv/asrc_host_tb.sv */
// self-checking testbench for the static memory host controller
`timescale 1ns/1ps
module asrc_host_tb;
  logic CLK = 0, NRST = 0, REQ_VALID = 0, REQ_WRITE = 0, CE = 1;
  logic [17:0] REQ_ADDR = 18'h0_0000;
  logic [15:0] REQ_WDATA = 16'h0000;
  logic [1:0] REQ_BYTE_EN = 2'h0;
  logic REQ_READY, RSP_VALID, cs_n, we_n, od_n, lo_n, hi_n, oe, clash;
  logic [15:0] RSP_RDATA, dout, bus;
  logic [17:0] addr;
  logic [15:0] q;
  int n_mismatch = 0;
  int compares = 0;
  always #4 CLK = ~CLK;
  asrc_host dut (.CLK(CLK), .NRST(NRST), .CE(CE), .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
    .REQ_BYTE_EN(REQ_BYTE_EN), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_RDATA(RSP_RDATA), .WORD_ADDRESS(addr), .CHIP_SELECT_N(cs_n),
    .WRITE_STROBE_N(we_n), .OUTPUT_DRIVE_N(od_n), .LOW_BYTE_LANE_N(lo_n),
    .HIGH_BYTE_LANE_N(hi_n), .DATA_LINES_O(dout), .DATA_LINES_OE(oe),
    .DATA_LINES_I(bus));
  asrc_mem_model mem (.word_address(addr), .chip_select_n(cs_n), .write_strobe_n(we_n),
    .output_drive_n(od_n), .low_byte_lane_n(lo_n), .high_byte_lane_n(hi_n),
    .host_o(dout), .host_oe(oe), .data_lines(bus), .clash(clash), .standby());
  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic fail(input string m);
    n_mismatch++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("data %h expected %h", got, exp));
  endtask
  // one request; for a read, waits for the answer pulse and returns its data
  task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d,
      input logic [1:0] be, output logic [15:0] r);
    int n;
    n = 0;
    // ready is looked at off the edge, never in the step that updates it
    #1;
    while (REQ_READY !== 1'b1) begin
      @(posedge CLK);
      #1;
      n++;
      if (n > 50) begin fail("ready timeout"); finish_test(); end
    end
    @(posedge CLK);
    REQ_VALID <= 1'b1; REQ_WRITE <= w; REQ_ADDR <= a; REQ_WDATA <= d; REQ_BYTE_EN <= be;
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    r = 16'h0000;
    n = 0;
    while (!w) begin
      @(posedge CLK);
      #1;
      if (RSP_VALID === 1'b1) begin r = RSP_RDATA; break; end
      n++;
      if (n > 30) begin fail("answer timeout"); finish_test(); end
    end
  endtask
  task automatic t_full_word();
    op(1, 18'h3_ffff, 16'h1234, 2'h3, q);
    op(1, 18'h0_0000, 16'hbeef, 2'h3, q);
    op(0, 18'h3_ffff, 16'h0000, 2'h3, q);
    chk(q, 16'h1234);
    op(0, 18'h0_0000, 16'h0000, 2'h3, q);
    chk(q, 16'hbeef);
  endtask
  task automatic t_lanes();
    op(1, 18'h0_1234, 16'ha5a5, 2'h3, q);
    op(1, 18'h0_1234, 16'h005a, 2'h1, q);
    op(0, 18'h0_1234, 16'h0000, 2'h3, q);
    chk(q, 16'ha55a);
    op(1, 18'h0_1234, 16'h3c00, 2'h2, q);
    op(0, 18'h0_1234, 16'h0000, 2'h3, q);
    chk(q, 16'h3c5a);
    // a disabled lane stays released and shows the inverse of the last host data
    op(0, 18'h0_1234, 16'h0000, 2'h1, q);
    chk(q, 16'hc35a);
    op(0, 18'h0_1234, 16'h0000, 2'h2, q);
    chk(q, 16'h3cff);
  endtask
  task automatic t_no_lane();
    op(1, 18'h0_1234, 16'hffff, 2'h0, q);
    repeat (12) begin
      @(posedge CLK);
      #1;
      compares++;
      if (cs_n !== 1'b1) fail("select moved on empty write");
    end
    op(0, 18'h0_1234, 16'h0000, 2'h3, q);
    chk(q, 16'h3c5a);
  endtask
  // low clock enable in mid-read freezes pins and answer; the read then completes
  task automatic t_freeze();
    int n;
    n = 0;
    fork
      op(0, 18'h0_1234, 16'h0000, 2'h3, q);
      begin
        while (!(REQ_VALID === 1'b1 && REQ_READY === 1'b1)) begin
          @(posedge CLK);
          #1;
          n++;
          if (n > 50) begin fail("take timeout"); finish_test(); end
        end
        repeat (2) @(posedge CLK);
        CE <= 1'b0;
        repeat (10) begin
          @(posedge CLK);
          #1;
          compares++;
          if (cs_n !== 1'b0 || od_n !== 1'b0 || RSP_VALID !== 1'b0)
            fail("pins moved while frozen");
        end
        @(posedge CLK);
        CE <= 1'b1;
      end
    join
    chk(q, 16'h3c5a);
  endtask
  always @(posedge CLK) begin
    if (clash === 1'b1) fail("both parties drive the lines");
  end
  initial begin
    repeat (5) @(posedge CLK);
    NRST <= 1'b1;
    repeat (2) @(posedge CLK);
    t_full_word();
    t_lanes();
    t_no_lane();
    t_freeze();
    finish_test();
  end
endmodule
